// ### rtl/io_pad_bank.sv
`timescale 1ns/10ps
`include "io_ports_defs.svh"

module io_pad_bank #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] od,
  input  wire logic [W-1:0] rmw_latch,
  input  wire logic [W-1:0] hiz,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_sync,
  output logic      [W-1:0] rd_data
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] out_r;
  logic [W-1:0] oe_r;
  logic [W-1:0] out_nxt;
  logic [W-1:0] oe_nxt;

  // open-drain bits only ever sink; a latch of 1 releases the pin
  assign out_nxt = latch & ~od;
  assign oe_nxt  = dir & ~hiz & (~od | ~latch);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
      out_r  <= '0;
      oe_r   <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      out_r  <= out_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // no input latch: reads see the synchronised pin unless rmw selects latch
  assign rd_data  = (rmw_latch & latch) | (~rmw_latch & sync_r);
  assign pin_out  = out_r;
  assign pin_oe   = oe_r;
  assign pin_sync = sync_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_od_sink_only: assert property ((oe_r & out_r & $past(od)) == '0)
    else $error("open-drain pin driven high");
  a_drive_needs_dir: assert property ((oe_r & ~$past(dir)) == '0)
    else $error("pin driven while direction is input");

endmodule

// ### rtl/io_ports.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "io_ports_defs.svh"

// How it works
// - outputs latched, inputs read live pin
// - pin sampled in state S1 of read
// - write lands in latch during state S2
// - listed rmw instructions read latch, others pin
// - port0 four bits, direction resets input
// - port0 output latch resets to zero
// - port0 open-drain select resets to push-pull
// - port0 open-drain rmw reads latch
// - port1 eight bits, per-bit direction, resets input
// - port1 latch read/write, resets to zero
// - port2 three bits, latch resets ones
// - port2 reads valid only bits 2..0
// - port2 rmw reads latch, others pin
// - port2 falling edge sets interrupt latch always
// - deep sleep floats port2 bit0 regardless
module io_ports #(
  parameter logic [7:0] STATE_CYCLES = `IOP_STATE_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  port0_pin_in,
  output logic      [3:0]  port0_pin_out,
  output logic      [3:0]  port0_pin_oe,
  input  wire logic [7:0]  port1_pin_in,
  output logic      [7:0]  port1_pin_out,
  output logic      [7:0]  port1_pin_oe,
  input  wire logic [2:0]  port2_pin_in,
  output logic      [2:0]  port2_pin_out,
  output logic      [2:0]  port2_pin_oe,
  output logic      [2:0]  ext_int_latch
);

  localparam int P0W = `IOP_P0_W;
  localparam int P1W = `IOP_P1_W;
  localparam int P2W = `IOP_P2_W;

  // instruction state sequencer
  io_ports_pkg::phase_t phase_r;
  io_ports_pkg::phase_t phase_nxt;
  logic [7:0]           div_cnt_r;
  logic                 state_end;
  logic                 state_start;

  assign state_end   = (div_cnt_r == STATE_CYCLES - 8'h01);
  assign state_start = (div_cnt_r == 8'h00);

  always_comb
  begin
    unique case (phase_r)
      io_ports_pkg::PH_S1: phase_nxt = io_ports_pkg::PH_S2;
      io_ports_pkg::PH_S2: phase_nxt = io_ports_pkg::PH_S3;
      io_ports_pkg::PH_S3: phase_nxt = io_ports_pkg::PH_S4;
      io_ports_pkg::PH_S4: phase_nxt = io_ports_pkg::PH_S1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      div_cnt_r <= 8'h00;
      phase_r   <= io_ports_pkg::PH_S1;
    end
    else if (state_end)
    begin
      div_cnt_r <= 8'h00;
      phase_r   <= phase_nxt;
    end
    else
      div_cnt_r <= div_cnt_r + 8'h01;
  end

  // registers
  logic [P0W-1:0]        p0_latch_r;
  logic [P0W-1:0]        p0_dir_r;
  logic [P0W-1:0]        p0_od_r;
  logic [P1W-1:0]        p1_latch_r;
  logic [P1W-1:0]        p1_dir_r;
  logic [P2W-1:0]        p2_latch_r;
  io_ports_pkg::sysctl_t sysctl_r;
  logic                  rmw_r;
  logic [P2W-1:0]        ext_int_r;

  // apb decode
  logic [13:0] idx;
  logic        mapped;
  logic        acc_open;
  logic        accept;
  logic        commit;
  logic        wr_byte;

  assign idx      = paddr[15:2];
  assign mapped   = (paddr[1:0] == 2'h0) &&
                    (idx == `IOP_IDX_P0_LATCH || idx == `IOP_IDX_P1_LATCH ||
                     idx == `IOP_IDX_P2_LATCH || idx == `IOP_IDX_P0_DIR ||
                     idx == `IOP_IDX_P1_DIR || idx == `IOP_IDX_P0_ODSEL ||
                     idx == `IOP_IDX_SYSCTL || idx == `IOP_IDX_ACCESS ||
                     idx == `IOP_IDX_EXTINT);
  assign acc_open = psel && penable && !pready;
  // reads wait for S1, writes for S2, so the bus stalls up to one instruction cycle
  assign accept   = acc_open && (!mapped || (state_start &&
                    (pwrite ? (phase_r == io_ports_pkg::PH_S2)
                            : (phase_r == io_ports_pkg::PH_S1))));
  assign commit   = psel && penable && pready && pwrite && !pslverr;
  assign wr_byte  = commit && pstrb[0];

  logic wr_p0_latch;
  logic wr_p1_latch;
  logic wr_p2_latch;
  logic wr_p0_dir;
  logic wr_p1_dir;
  logic wr_p0_od;
  logic wr_sysctl;
  logic wr_access;
  logic wr_extint;

  assign wr_p0_latch = wr_byte && idx == `IOP_IDX_P0_LATCH;
  assign wr_p1_latch = wr_byte && idx == `IOP_IDX_P1_LATCH;
  assign wr_p2_latch = wr_byte && idx == `IOP_IDX_P2_LATCH;
  assign wr_p0_dir   = wr_byte && idx == `IOP_IDX_P0_DIR;
  assign wr_p1_dir   = wr_byte && idx == `IOP_IDX_P1_DIR;
  assign wr_p0_od    = wr_byte && idx == `IOP_IDX_P0_ODSEL;
  assign wr_sysctl   = wr_byte && idx == `IOP_IDX_SYSCTL;
  assign wr_access   = wr_byte && idx == `IOP_IDX_ACCESS;
  assign wr_extint   = wr_byte && idx == `IOP_IDX_EXTINT;

  // pad banks
  logic [P0W-1:0] p0_rd;
  logic [P1W-1:0] p1_rd;
  logic [P2W-1:0] p2_rd;
  logic [P2W-1:0] p2_sync;
  logic           sleep_float;
  logic [P0W-1:0] p0_hiz;
  logic [P1W-1:0] p1_hiz;
  logic [P2W-1:0] p2_hiz;

  assign sleep_float = sysctl_r.deep_sleep_entry && !sysctl_r.sleep_output_hold_enable;
  assign p0_hiz      = {P0W{sleep_float}};
  assign p1_hiz      = {P1W{sleep_float}};
  // bit0 doubles as the sleep-release input, so the hold enable cannot keep it driven
  assign p2_hiz      = {P2W{sleep_float}} |
                       ({{(P2W-1){1'b0}}, sysctl_r.deep_sleep_entry}
                        << `IOP_P2_SLEEP_PIN);

  io_pad_bank #(.W(P0W)) u_port0 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (port0_pin_in),
    .latch     (p0_latch_r),
    .dir       (p0_dir_r),
    .od        (p0_od_r),
    .rmw_latch ({P0W{rmw_r}} & p0_od_r),
    .hiz       (p0_hiz),
    .pin_out   (port0_pin_out),
    .pin_oe    (port0_pin_oe),
    .pin_sync  (),
    .rd_data   (p0_rd)
  );

  // port1 is programmable: reads always see the pin
  io_pad_bank #(.W(P1W)) u_port1 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (port1_pin_in),
    .latch     (p1_latch_r),
    .dir       (p1_dir_r),
    .od        ({P1W{1'b0}}),
    .rmw_latch ({P1W{1'b0}}),
    .hiz       (p1_hiz),
    .pin_out   (port1_pin_out),
    .pin_oe    (port1_pin_oe),
    .pin_sync  (),
    .rd_data   (p1_rd)
  );

  // port2 has no direction register: a latch of 1 releases the pin for input
  io_pad_bank #(.W(P2W)) u_port2 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (port2_pin_in),
    .latch     (p2_latch_r),
    .dir       ({P2W{1'b1}}),
    .od        ({P2W{1'b1}}),
    .rmw_latch ({P2W{rmw_r}}),
    .hiz       (p2_hiz),
    .pin_out   (port2_pin_out),
    .pin_oe    (port2_pin_oe),
    .pin_sync  (p2_sync),
    .rd_data   (p2_rd)
  );

  // falling edge seen even while this port drives the pin itself
  logic [P2W-1:0] p2_prev_r;
  logic [P2W-1:0] p2_fall;
  logic [P2W-1:0] ext_int_nxt;

  assign p2_fall     = p2_prev_r & ~p2_sync;
  assign ext_int_nxt = (ext_int_r & ~(wr_extint ? pwdata[P2W-1:0] : {P2W{1'b0}}))
                       | p2_fall;

  // read mux
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (idx)
      `IOP_IDX_P0_LATCH: rd_word[P0W-1:0] = p0_rd;
      `IOP_IDX_P1_LATCH: rd_word[P1W-1:0] = p1_rd;
      `IOP_IDX_P2_LATCH: rd_word[P2W-1:0] = p2_rd;
      `IOP_IDX_P0_DIR:   rd_word[P0W-1:0] = p0_dir_r;
      `IOP_IDX_P1_DIR:   rd_word[P1W-1:0] = p1_dir_r;
      `IOP_IDX_P0_ODSEL: rd_word[P0W-1:0] = p0_od_r;
      `IOP_IDX_SYSCTL:   rd_word[1:0]     = sysctl_r;
      `IOP_IDX_ACCESS:   rd_word[0]       = rmw_r;
      `IOP_IDX_EXTINT:   rd_word[P2W-1:0] = ext_int_r;
      default:           rd_word          = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= accept;
      pslverr <= accept && !mapped;
      if (accept && !pwrite)
        prdata <= rd_word;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      p0_latch_r <= `IOP_P0_LATCH_RST;
      p0_dir_r   <= `IOP_P0_DIR_RST;
      p0_od_r    <= `IOP_P0_ODSEL_RST;
      p1_latch_r <= `IOP_P1_LATCH_RST;
      p1_dir_r   <= `IOP_P1_DIR_RST;
      p2_latch_r <= `IOP_P2_LATCH_RST;
      sysctl_r   <= '0;
      rmw_r      <= 1'b0;
      ext_int_r  <= '0;
      // history starts low like the cleared synchroniser, so release shows no edge
      p2_prev_r  <= '0;
    end
    else
    begin
      // registers only change on a committed write and hold otherwise; the interrupt latch also sets on a port2 falling edge, and p2_prev_r follows p2_sync every cycle
      if (wr_p0_latch) p0_latch_r <= pwdata[P0W-1:0];
      if (wr_p1_latch) p1_latch_r <= pwdata[P1W-1:0];
      if (wr_p2_latch) p2_latch_r <= pwdata[P2W-1:0];
      if (wr_p0_dir)   p0_dir_r   <= pwdata[P0W-1:0];
      if (wr_p1_dir)   p1_dir_r   <= pwdata[P1W-1:0];
      if (wr_p0_od)    p0_od_r    <= pwdata[P0W-1:0];
      if (wr_sysctl)   sysctl_r   <= pwdata[1:0];
      if (wr_access)   rmw_r      <= pwdata[`IOP_ACCESS_RMW_BIT];
      ext_int_r <= ext_int_nxt;
      p2_prev_r <= p2_sync;
    end
  end

  assign ext_int_latch = ext_int_r;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_accept;
    accept && !pwrite && mapped;
  endsequence

  sequence s_write_accept;
    accept && pwrite && mapped;
  endsequence

  a_read_in_s1: assert property (s_read_accept |-> phase_r == io_ports_pkg::PH_S1)
    else $error("read sampled outside S1");
  a_write_in_s2: assert property (s_write_accept ##1 commit |->
      phase_r == io_ports_pkg::PH_S2 && $past(phase_r) == io_ports_pkg::PH_S2)
    else $error("write landed outside S2");
  a_p1_latch_holds: assert property (!wr_p1_latch |=> $stable(p1_latch_r))
    else $error("port1 latch changed without write");
  a_p0_reset_input: assert property ($rose(rst_n) |-> p0_dir_r == 4'h0 &&
      p0_latch_r == 4'h0 && port0_pin_oe == 4'h0)
    else $error("port0 not in input mode after reset");
  a_p0_od_reset: assert property ($rose(rst_n) |-> p0_od_r == 4'h0)
    else $error("port0 open-drain select not cleared");
  a_p1_reset: assert property ($rose(rst_n) |-> p1_dir_r == 8'h00 &&
      p1_latch_r == 8'h00)
    else $error("port1 not reset to input with zero latch");
  a_p2_reset_ones: assert property ($rose(rst_n) |-> p2_latch_r == 3'h7)
    else $error("port2 latch not reset to ones");
  a_p2_upper_zero: assert property (s_read_accept ##0 (idx == `IOP_IDX_P2_LATCH)
      |=> pready && prdata[31:3] == 29'h0000_0000)
    else $error("port2 upper bits not zero");
  a_p2_rmw_latch: assert property (s_read_accept ##0 (idx == `IOP_IDX_P2_LATCH && rmw_r)
      |=> prdata[2:0] == $past(p2_latch_r))
    else $error("port2 rmw read did not return latch");
  a_edge_sets_int: assert property ((p2_fall != 3'h0) |=>
      (ext_int_r & $past(p2_fall)) == $past(p2_fall))
    else $error("falling edge lost on port2");
  a_sleep_float: assert property (sysctl_r.deep_sleep_entry ##1
      sysctl_r.deep_sleep_entry |-> !port2_pin_oe[0])
    else $error("port2 bit0 driven in deep sleep");

endmodule

// ### rtl/io_ports_defs.svh
`ifndef IO_PORTS_DEFS_SVH
`define IO_PORTS_DEFS_SVH

// register indices; byte address is four times the index
`define IOP_IDX_P0_LATCH   14'h0000
`define IOP_IDX_P1_LATCH   14'h0001
`define IOP_IDX_P2_LATCH   14'h0002
`define IOP_IDX_P0_DIR     14'h000A
`define IOP_IDX_P1_DIR     14'h000B
`define IOP_IDX_P0_ODSEL   14'h000C
`define IOP_IDX_SYSCTL     14'h000D
`define IOP_IDX_ACCESS     14'h000E
`define IOP_IDX_EXTINT     14'h000F

`define IOP_P0_W           4
`define IOP_P1_W           8
`define IOP_P2_W           3

`define IOP_P0_LATCH_RST   4'h0
`define IOP_P0_DIR_RST     4'h0
`define IOP_P0_ODSEL_RST   4'h0
`define IOP_P1_LATCH_RST   8'h00
`define IOP_P1_DIR_RST     8'h00
`define IOP_P2_LATCH_RST   3'h7

// field positions
`define IOP_ACCESS_RMW_BIT 0
`define IOP_P2_SLEEP_PIN   0

// core clock cycles spent in each instruction state
`define IOP_STATE_CYCLES   8'h02

`endif

// ### rtl/io_ports_pkg.sv
package io_ports_pkg;

  typedef enum logic [1:0] {
    PH_S1 = 2'b00,
    PH_S2 = 2'b01,
    PH_S3 = 2'b10,
    PH_S4 = 2'b11
  } phase_t;

  typedef struct packed {
    logic sleep_output_hold_enable;
    logic deep_sleep_entry;
  } sysctl_t;

endpackage

// ### verif/board_model.sv
`timescale 1ns/10ps

module board_model #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] drive_en,
  input  wire logic [W-1:0] drive_val,
  output logic      [W-1:0] pin_in
);
  // a released line the board does not drive goes to the pull-up, never keeps a stale level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_en & drive_val)
                | (~pin_oe & ~drive_en);
endmodule

// ### verif/testbench.sv
`timescale 1ns/10ps
`include "io_ports_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end

module testbench;
  logic        core_clk, rst_n, psel, penable, pwrite, pslverr, pready, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb, port0_pin_out, port0_pin_oe, port0_pin_in, b0e, b0v, m0_lat, m0_dir, m0_od;
  logic [7:0]  port1_pin_out, port1_pin_oe, port1_pin_in, b1e, b1v, m1_lat, m1_dir, rnd;
  logic [2:0]  port2_pin_out, port2_pin_oe, port2_pin_in, b2e, b2v, ext_int_latch, m2_lat;
  logic [1:0]  m_sys;
  int          n_errors, checked, cycles;

  io_ports #(.STATE_CYCLES(8'h02)) i_dut (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .port0_pin_in, .port0_pin_out, .port0_pin_oe, .port1_pin_in,
    .port1_pin_out, .port1_pin_oe, .port2_pin_in, .port2_pin_out, .port2_pin_oe,
    .ext_int_latch
  );
  board_model #(.W(4)) i_b0 (.pin_out(port0_pin_out), .pin_oe(port0_pin_oe),
    .drive_en(b0e), .drive_val(b0v), .pin_in(port0_pin_in));
  board_model #(.W(8)) i_b1 (.pin_out(port1_pin_out), .pin_oe(port1_pin_oe),
    .drive_en(b1e), .drive_val(b1v), .pin_in(port1_pin_in));
  board_model #(.W(3)) i_b2 (.pin_out(port2_pin_out), .pin_oe(port2_pin_oe),
    .drive_en(b2e), .drive_val(b2v), .pin_in(port2_pin_in));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic [7:0] pins(input logic [7:0] oe, out, be, bv);
    return (oe & out) | (~oe & be & bv) | (~oe & ~be);
  endfunction

  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(q, exp)
  endtask

  task automatic chk_pins();
    logic z;
    z = m_sys[0] & ~m_sys[1];
    repeat (4) @(posedge core_clk);
    `CHK(port0_pin_oe, z ? 4'h0 : m0_dir & (~m0_od | ~m0_lat))
    `CHK(port0_pin_out, m0_lat & ~m0_od)
    `CHK(port1_pin_oe, z ? 8'h00 : m1_dir)
    `CHK(port1_pin_out, m1_lat)
    `CHK(port2_pin_oe, z ? 3'h0 : ~m2_lat & {2'b11, ~m_sys[0]})
    `CHK(port2_pin_out, 3'h0)
  endtask

  task automatic summarize();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {b0e, b0v, b2e, b2v, m0_lat, m0_dir, m0_od, m1_lat, m1_dir, m_sys} = '0;
    b1e = 8'hFF;
    b1v = 8'h00;
    m2_lat = 3'h7;
    rnd = 8'h38;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_pins();
    rd(`IOP_IDX_P0_DIR, 32'h0);
    rd(`IOP_IDX_P0_ODSEL, 32'h0);
    rd(`IOP_IDX_P1_DIR, 32'h0);
    `CHK(err, 1'b0)
    `CHK(ext_int_latch, 3'h0)
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      m1_dir = rnd;
      rnd = lfsr(rnd);
      m1_lat = rnd;
      rnd = lfsr(rnd);
      b1v <= rnd;
      apb(1'b1, `IOP_IDX_P1_DIR, {24'h0, m1_dir});
      apb(1'b1, `IOP_IDX_P1_LATCH, {24'h0, m1_lat});
      chk_pins();
      rd(`IOP_IDX_P1_LATCH, {24'h0, pins(m1_dir, m1_lat, 8'hFF, b1v)});
    end
    // byte 0 strobe off: the write completes but the latch must hold
    pstrb <= 4'hE;
    apb(1'b1, `IOP_IDX_P1_LATCH, {24'h0, ~m1_lat});
    pstrb <= 4'hF;
    rd(`IOP_IDX_P1_DIR, {24'h0, m1_dir});
    chk_pins();
    $display("test port1 done");
    {m0_dir, m0_od, m0_lat} = {4'hF, 4'h5, 4'h3};
    b0e <= 4'h1;
    apb(1'b1, `IOP_IDX_P0_DIR, 32'hF);
    apb(1'b1, `IOP_IDX_P0_ODSEL, 32'h5);
    apb(1'b1, `IOP_IDX_P0_LATCH, 32'h3);
    chk_pins();
    rd(`IOP_IDX_P0_LATCH, 32'h2);
    apb(1'b1, `IOP_IDX_ACCESS, 32'h1);
    rd(`IOP_IDX_P0_LATCH, 32'h3);
    rd(`IOP_IDX_P1_LATCH, {24'h0, pins(m1_dir, m1_lat, 8'hFF, b1v)});
    $display("test port0 done");
    m2_lat = 3'h2;
    b2e <= 3'h2;
    apb(1'b1, `IOP_IDX_P2_LATCH, 32'h2);
    chk_pins();
    rd(`IOP_IDX_P2_LATCH, 32'h2);
    // latch reads stop before the interrupt latch is touched
    apb(1'b1, `IOP_IDX_ACCESS, 32'h0);
    rd(`IOP_IDX_P2_LATCH, 32'h0);
    `CHK(ext_int_latch, 3'h7)
    rd(`IOP_IDX_EXTINT, 32'h7);
    $display("test port2 done");
    for (int s = 3; s >= 0; s = s - 1)
    begin
      m_sys = s[1:0];
      apb(1'b1, `IOP_IDX_SYSCTL, s);
      chk_pins();
      rd(`IOP_IDX_SYSCTL, s);
    end
    m_sys = 2'b00;
    apb(1'b1, `IOP_IDX_SYSCTL, 32'h0);
    chk_pins();
    m2_lat = 3'h7;
    b2e <= 3'h0;
    apb(1'b1, `IOP_IDX_P2_LATCH, 32'h7);
    apb(1'b1, `IOP_IDX_EXTINT, 32'h7);
    repeat (4) @(posedge core_clk);
    `CHK(ext_int_latch, 3'h0)
    $display("test sleep done");
    apb(1'b0, 14'h0010, 32'h0);
    `CHK(err, 1'b1)
    $display("test unmapped done");
    summarize();
  end
endmodule
